// File: plc_channel.sv
// Probe latch package and one latch channel.
// Assumes all trigger inputs and the position count are synchronous to
// the system clock; the top module owns the registers and the bus.
`timescale 1ns/1ps
`default_nettype none

package plc_pkg;
    // Register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MASK   = 8'h08;
    localparam logic [7:0] OFF_RES1   = 8'h0c;
    localparam logic [7:0] OFF_RES2   = 8'h10;
    localparam logic [7:0] OFF_ALTSEL = 8'h14;
    localparam logic [7:0] OFF_STATE  = 8'h18;

    // Control word layout, channel one fields; channel two sits one
    // stride higher
    localparam int CTRL_W          = 16;
    localparam int CH_STRIDE       = 8;
    localparam int BIT_ENABLE      = 0;
    localparam int BIT_CONTINUOUS  = 1;
    localparam int BIT_SRC_SEL     = 2;
    localparam int BIT_RISE_EN     = 4;
    localparam int BIT_FALL_EN     = 5;
    localparam logic [15:0] CTRL_RESET = 16'h0000;

    // Status, mask and state layouts
    localparam int NUM_CH          = 2;
    localparam logic [1:0] STATUS_RESET = 2'h0;
    localparam logic [1:0] MASK_RESET   = 2'h0;
    localparam logic [1:0] ALTSEL_RESET = 2'h0;
    localparam int STATE_ARMED_POS = 0;  // Two bits, one per channel
    localparam int STATE_DONE_POS  = 2;
    localparam int STATE_RISE_POS  = 4;

    localparam int POS_WIDTH       = 32;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Settings of one channel
    typedef struct packed {
        logic enable;
        logic continuous;
        logic src_sel;     // 0: external input, 1: internal output
        logic alt_sel;     // With src_sel: 0 zero-phase, 1 step timing
        logic rise_en;
        logic fall_en;
    } plc_chan_cfg_t;

    // What a channel reports back
    typedef struct packed {
        logic armed;
        logic done;
        logic last_rise;   // Last capture came from a rising edge
    } plc_chan_stat_t;

    typedef enum logic [2:0] {
        CH_OFF   = 3'b001,
        CH_ARMED = 3'b010,
        CH_DONE  = 3'b100
    } plc_ch_state_t;
endpackage

module plc_channel
    import plc_pkg::*;
#(
    parameter int POS_W = POS_WIDTH
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  var  plc_chan_cfg_t     cfg,
    input  wire logic              ext_in,
    input  wire logic              zsg_in,
    input  wire logic              tim_in,
    input  wire logic [POS_W-1:0]  position,
    output logic      [POS_W-1:0]  result,
    output logic                   latched,
    output plc_chan_stat_t         stat
);
    plc_ch_state_t state;
    logic          trig;
    logic          prev_trig;
    logic          prev_valid;
    logic [1:0]    prev_sel;
    logic          rise;
    logic          fall;
    logic          hit;
    logic          last_rise;

    // Source choice uses only this channel's bits
    always_comb begin
        if (cfg.src_sel) begin
            trig = cfg.alt_sel ? tim_in : zsg_in;
        end else begin
            trig = ext_in;
        end
    end

    // Previous sample; a change of source would fake an edge, so edges
    // are ignored for two cycles after the selection moves
    always_ff @(posedge clk) begin
        if (rst) begin
            prev_trig  <= 1'b0;
            prev_valid <= 1'b0;
            prev_sel   <= 2'h0;
        end else begin
            prev_trig  <= trig;
            prev_sel   <= {cfg.src_sel, cfg.alt_sel};
            prev_valid <= (prev_sel == {cfg.src_sel, cfg.alt_sel});
        end
    end

    // Qualified edges; the live compare blinds the first cycle after a
    // selection move, prev_valid the second, so a swap never fakes a hit
    assign rise = trig & ~prev_trig & cfg.rise_en;
    assign fall = ~trig & prev_trig & cfg.fall_en;
    assign hit  = (state == CH_ARMED) && prev_valid
                  && (prev_sel == {cfg.src_sel, cfg.alt_sel})
                  && (rise || fall);

    // Enable, single shot and continuous behaviour
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= CH_OFF;
        end else if (!cfg.enable) begin
            state <= CH_OFF;
        end else begin
            case (state)
                CH_OFF: begin
                    state <= CH_ARMED;
                end
                CH_ARMED: begin
                    if (hit && !cfg.continuous) begin
                        state <= CH_DONE;
                    end
                end
                CH_DONE: begin
                    if (cfg.continuous) begin
                        state <= CH_ARMED;
                    end
                end
                default: begin
                    state <= CH_OFF;
                end
            endcase
        end
    end

    // Capture the count of the same cycle in which the edge is seen
    always_ff @(posedge clk) begin
        if (rst) begin
            result    <= '0;
            latched   <= 1'b0;
            last_rise <= 1'b0;
        end else begin
            latched <= hit;
            if (hit) begin
                result    <= position;
                last_rise <= rise;
            end
        end
    end

    // Report word built in one place so the struct has a single driver
    assign stat = '{armed:     (state == CH_ARMED),
                    done:      (state == CH_DONE),
                    last_rise: last_rise};
endmodule

`default_nettype wire

// File: plc_top.sv
// Probe latch control: two latch channels behind an AXI4-Lite slave.
// Assumes latch and encoder-derived inputs are already synchronous to
// SYS_CLK and that POSITION is a free-running count in the same domain.
`timescale 1ns/1ps
`default_nettype none

module plc_top
    import plc_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int POS_W  = POS_WIDTH
) (
    input  wire logic              SYS_CLK,
    input  wire logic              RESET,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input  wire logic              S_AXI_AWVALID,
    output logic                   S_AXI_AWREADY,
    // AXI4-Lite write data
    input  wire logic [31:0]       S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output logic                   S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0]             S_AXI_BRESP,
    output logic                   S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input  wire logic              S_AXI_ARVALID,
    output logic                   S_AXI_ARREADY,
    // AXI4-Lite read data
    output logic [31:0]            S_AXI_RDATA,
    output logic [1:0]             S_AXI_RRESP,
    output logic                   S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY,
    // Trigger sources and position count
    input  wire logic              EXTERNAL_LATCH_INPUT_ONE,
    input  wire logic              ZERO_PHASE_SENSING_OUTPUT,
    input  wire logic              STEP_TIMING_OUTPUT,
    input  wire logic [POS_W-1:0]  POSITION,
    // Interrupt, level
    output logic                   IRQ
);
    // Registers
    logic [CTRL_W-1:0]  ctrl;
    logic [NUM_CH-1:0]  status;
    logic [NUM_CH-1:0]  mask;
    logic [NUM_CH-1:0]  altsel;

    // Write channel capture
    logic               aw_have;
    logic [ADDR_W-1:0]  aw_addr;
    logic               w_have;
    logic [31:0]        w_data;
    logic [3:0]         w_strb;
    logic               do_write;

    // Read side
    logic               ar_take;
    logic [31:0]        next_rdata;
    logic [1:0]         next_rresp;
    logic [NUM_CH-1:0]  status_clr;

    // Channel wiring
    plc_chan_cfg_t      cfg     [NUM_CH];
    plc_chan_stat_t     stat    [NUM_CH];
    logic [POS_W-1:0]   result  [NUM_CH];
    logic [NUM_CH-1:0]  latched;

    // Pull one channel's fields out of the control word; each channel
    // reads only its own byte so settings never cross over
    function automatic plc_chan_cfg_t chan_cfg(
        input logic [CTRL_W-1:0] word,
        input int                ch,
        input logic              alt
    );
        plc_chan_cfg_t c;
        int            base;
        base         = ch * CH_STRIDE;
        c.enable     = word[base + BIT_ENABLE];
        c.continuous = word[base + BIT_CONTINUOUS];
        c.src_sel    = word[base + BIT_SRC_SEL];
        c.alt_sel    = alt;
        c.rise_en    = word[base + BIT_RISE_EN];
        c.fall_en    = word[base + BIT_FALL_EN];
        return c;
    endfunction

    // Byte-lane merge for a write
    function automatic logic [31:0] merge_strb(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0]  strb
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Channel settings, one decode per channel
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            cfg[i] = chan_cfg(ctrl, i, altsel[i]);
        end
    end

    // Two independent latch channels
    plc_channel #(
        .POS_W    (POS_W)
    ) u_ch1 (
        .clk      (SYS_CLK),
        .rst      (RESET),
        .cfg      (cfg[0]),
        .ext_in   (EXTERNAL_LATCH_INPUT_ONE),
        .zsg_in   (ZERO_PHASE_SENSING_OUTPUT),
        .tim_in   (STEP_TIMING_OUTPUT),
        .position (POSITION),
        .result   (result[0]),
        .latched  (latched[0]),
        .stat     (stat[0])
    );

    plc_channel #(
        .POS_W    (POS_W)
    ) u_ch2 (
        .clk      (SYS_CLK),
        .rst      (RESET),
        .cfg      (cfg[1]),
        .ext_in   (EXTERNAL_LATCH_INPUT_ONE),
        .zsg_in   (ZERO_PHASE_SENSING_OUTPUT),
        .tim_in   (STEP_TIMING_OUTPUT),
        .position (POSITION),
        .result   (result[1]),
        .latched  (latched[1]),
        .stat     (stat[1])
    );

    // Write handshakes: each channel is taken on its own, in any order
    assign S_AXI_AWREADY = !aw_have && !S_AXI_BVALID;
    assign S_AXI_WREADY  = !w_have && !S_AXI_BVALID;
    assign do_write      = aw_have && w_have && !S_AXI_BVALID;

    // Hold address and data until both have arrived
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            aw_have <= 1'b0;
            aw_addr <= '0;
            w_have  <= 1'b0;
            w_data  <= 32'h0;
            w_strb  <= 4'h0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_have <= 1'b1;
                aw_addr <= S_AXI_AWADDR;
            end else if (do_write) begin
                aw_have <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_have <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
            end else if (do_write) begin
                w_have <= 1'b0;
            end
        end
    end

    // Write response; unmapped or read-only targets answer SLVERR
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= RESP_OKAY;
        end else if (do_write) begin
            S_AXI_BVALID <= 1'b1;
            case (aw_addr[7:0])
                OFF_CTRL, OFF_MASK, OFF_ALTSEL: begin
                    S_AXI_BRESP <= RESP_OKAY;
                end
                default: begin
                    S_AXI_BRESP <= RESP_SLVERR;
                end
            endcase
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // Control word; reserved bits are stored as written, since software
    // is expected to keep them zero and the channels never look at them
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            ctrl <= CTRL_RESET;
        end else if (do_write && aw_addr[7:0] == OFF_CTRL) begin
            ctrl <= CTRL_W'(merge_strb({16'h0, ctrl}, w_data,
                                       w_strb));
        end
    end

    // Mask and internal-source choice
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            mask   <= MASK_RESET;
            altsel <= ALTSEL_RESET;
        end else if (do_write && w_strb[0]) begin
            if (aw_addr[7:0] == OFF_MASK) begin
                mask <= w_data[NUM_CH-1:0];
            end
            if (aw_addr[7:0] == OFF_ALTSEL) begin
                altsel <= w_data[NUM_CH-1:0];
            end
        end
    end

    // Read handshake: one read in flight, answer one cycle after taking
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    assign ar_take       = S_AXI_ARVALID && S_AXI_ARREADY;

    // Read data select
    always_comb begin
        next_rdata = 32'h0;
        next_rresp = RESP_OKAY;
        case (S_AXI_ARADDR[7:0])
            OFF_CTRL: begin
                next_rdata[CTRL_W-1:0] = ctrl;
            end
            OFF_STATUS: begin
                next_rdata[NUM_CH-1:0] = status;
            end
            OFF_MASK: begin
                next_rdata[NUM_CH-1:0] = mask;
            end
            OFF_RES1: begin
                next_rdata = 32'(result[0]);
            end
            OFF_RES2: begin
                next_rdata = 32'(result[1]);
            end
            OFF_ALTSEL: begin
                next_rdata[NUM_CH-1:0] = altsel;
            end
            OFF_STATE: begin
                for (int i = 0; i < NUM_CH; i++) begin
                    next_rdata[STATE_ARMED_POS + i] = stat[i].armed;
                    next_rdata[STATE_DONE_POS + i]  = stat[i].done;
                    next_rdata[STATE_RISE_POS + i]  = stat[i].last_rise;
                end
            end
            default: begin
                next_rresp = RESP_SLVERR;
            end
        endcase
    end

    // Read data register, held until the master takes it
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h0;
            S_AXI_RRESP  <= RESP_OKAY;
        end else if (ar_take) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA  <= next_rdata;
            S_AXI_RRESP  <= next_rresp;
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // Reading status clears the bits that were returned
    assign status_clr = (ar_take && S_AXI_ARADDR[7:0] == OFF_STATUS)
                        ? status : '0;

    // Sticky latched flags; a capture in the clearing cycle survives
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            status <= STATUS_RESET;
        end else begin
            status <= (status & ~status_clr) | latched;
        end
    end

    // Level interrupt while any unmasked flag is set
    assign IRQ = |(status & mask);
endmodule

`default_nettype wire

// File: plc_sensor.sv
// Far-side model: latch sensor and encoder count for the probe latch.
// Assumes the bench pulses go for one cycle right after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module plc_sensor (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        go,
    input  wire logic [1:0]  line,
    input  wire logic        lvl,
    output logic             lat_in,
    output logic             zero_ph,
    output logic             step_tm,
    output logic [31:0]      pos,
    output logic [31:0]      stamp
);
    // Lines change only on a clock edge, so the latch sees clean levels;
    // stamp is the count that shows together with the new level
    always_ff @(posedge clk) begin
        if (rst) begin
            lat_in  <= 1'b0;
            zero_ph <= 1'b0;
            step_tm <= 1'b0;
            pos     <= 32'h0000_1000;
            stamp   <= 32'h0000_0000;
        end else begin
            pos <= pos + 32'h0000_0001;  // Free-running count
            if (go) begin
                stamp <= pos + 32'h0000_0001;
                case (line)
                    2'h0: lat_in <= lvl;
                    2'h1: zero_ph <= lvl;
                    default: step_tm <= lvl;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// File: plc_top_chk.sv
// Checker for the probe latch block: bus handshakes and interrupt causes.
// Assumes it is bound to plc_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module plc_chk (
    input wire logic        SYS_CLK,
    input wire logic        RESET,
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic [1:0]  S_AXI_BRESP,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    input wire logic        EXTERNAL_LATCH_INPUT_ONE,
    input wire logic        ZERO_PHASE_SENSING_OUTPUT,
    input wire logic        STEP_TIMING_OUTPUT,
    input wire logic        IRQ
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    logic [2:0] prev_trig;
    logic [3:0] trig_hist;
    logic [3:0] bus_hist;
    // Recent trigger changes and bus handshakes; IRQ may only move
    // after one of them
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            prev_trig <= 3'h0;
            trig_hist <= 4'h0;
            bus_hist  <= 4'h0;
        end else begin
            prev_trig <= {EXTERNAL_LATCH_INPUT_ONE,
                          ZERO_PHASE_SENSING_OUTPUT, STEP_TIMING_OUTPUT};
            trig_hist <= {trig_hist[2:0], prev_trig != {
                EXTERNAL_LATCH_INPUT_ONE, ZERO_PHASE_SENSING_OUTPUT,
                STEP_TIMING_OUTPUT}};
            bus_hist  <= {bus_hist[2:0],
                (S_AXI_AWVALID && S_AXI_AWREADY) ||
                (S_AXI_ARVALID && S_AXI_ARREADY)};
        end
    end
    // Write: both items taken, then a response two edges later
    sequence wr_taken;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    sequence wr_answer;
        !S_AXI_BVALID ##1 S_AXI_BVALID;
    endsequence
    wr_resp_a: assert property (wr_taken |=> wr_answer)
        else $error("write response not two edges after handshake");
    rd_resp_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=>
        S_AXI_RVALID) else $error("read data late");
    b_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
        S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped");
    r_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
        S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped");
    ar_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read address taken while data pending");
    w_block_a: assert property (S_AXI_BVALID |->
        !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write taken while response pending");
    irq_cause_a: assert property ($rose(IRQ) |->
        trig_hist != 4'h0 || bus_hist != 4'h0)
        else $error("interrupt rose without cause");
    irq_clear_a: assert property ($fell(IRQ) |-> bus_hist != 4'h0)
        else $error("interrupt fell without bus access");
    reset_idle_a: assert property (disable iff (1'b0) RESET |=>
        !S_AXI_BVALID && !S_AXI_RVALID && !IRQ)
        else $error("outputs not idle after reset");
endmodule
bind plc_top plc_chk plc_chk_inst (.*);
`default_nettype wire

// File: tb_probe_latch_control.sv
// Bench for the probe latch: AXI4-Lite master tasks and latch scenarios.
// Assumes plc_top, plc_chk and the plc_sensor far-side model.
`timescale 1ns/1ps
`default_nettype none
module tb_probe_latch_control
    import plc_pkg::*;
;
    logic sys_clk = 1'b0, reset = 1'b1, go = 1'b0, lvl = 1'b0;
    logic [1:0] line = 2'h0, msk = 2'h0, bresp, rresp;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, pos, stamp, d;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic rready = 1'b0, awready, wready, bvalid, arready, rvalid, irq;
    logic lat_in, zero_ph, step_tm;
    int fail_count = 0, checks = 0;
    // 125 MHz
    always #4 sys_clk = ~sys_clk;
    plc_sensor plc_sensor_inst (.clk(sys_clk), .rst(reset), .go(go),
        .line(line), .lvl(lvl), .lat_in(lat_in), .zero_ph(zero_ph),
        .step_tm(step_tm), .pos(pos), .stamp(stamp));
    plc_top plc_top_inst (.SYS_CLK(sys_clk), .RESET(reset),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .EXTERNAL_LATCH_INPUT_ONE(lat_in),
        .ZERO_PHASE_SENSING_OUTPUT(zero_ph),
        .STEP_TIMING_OUTPUT(step_tm), .POSITION(pos), .IRQ(irq));
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic hang(input string nm);
        fail_count++;
        $display("[ERR] %s expected answer seen timeout", nm);
        give_verdict();
    endtask
    // One write; readies sampled at the edge, items released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      input logic [1:0] er);
        logic aw, w, b;
        aw = 1'b1;
        w = 1'b1;
        b = 1'b0;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 40 && !b; n++) begin
            @(posedge sys_clk);
            if (aw && awready) begin aw = 1'b0; awvalid <= 1'b0; end
            if (w && wready) begin w = 1'b0; wvalid <= 1'b0; end
            if (bvalid) begin
                b = 1'b1;
                bready <= 1'b0;
                chk("bresp", {30'h0, er}, {30'h0, bresp});
            end
        end
        if (!b) hang("bvalid");
    endtask
    // One read, compared with its expected data and response
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        logic r;
        r = 1'b0;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 40 && !r; n++) begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                r = 1'b1;
                rready <= 1'b0;
                chk($sformatf("reg %h", a), e, rdata);
                chk("rresp", {30'h0, er}, {30'h0, rresp});
            end
        end
        if (!r) hang("rvalid");
    endtask
    task automatic ctl(input logic [31:0] v);
        wr(OFF_CTRL, v, RESP_OKAY);
    endtask
    // Move one sensor line, then check IRQ, status and captured counts
    task automatic fire(input logic [1:0] l, input logic v,
                        input logic [1:0] es);
        @(posedge sys_clk);
        go <= 1'b1;
        line <= l;
        lvl <= v;
        @(posedge sys_clk);
        go <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        d = stamp;
        chk("irq", {31'h0, |(es & msk)}, {31'h0, irq});
        rd(OFF_STATUS, {30'h0, es}, RESP_OKAY);
        chk("irq clear", 32'h0, {31'h0, irq});
        if (es[0]) rd(OFF_RES1, d, RESP_OKAY);
        if (es[1]) rd(OFF_RES2, d, RESP_OKAY);
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        // Reset values, unmapped and read-only places
        rd(OFF_CTRL, 32'h0, RESP_OKAY);
        rd(OFF_MASK, 32'h0, RESP_OKAY);
        rd(OFF_STATUS, 32'h0, RESP_OKAY);
        rd(OFF_ALTSEL, 32'h0, RESP_OKAY);
        rd(8'h1c, 32'h0, RESP_SLVERR);
        wr(8'h1c, 32'h1, RESP_SLVERR);
        wr(OFF_STATUS, 32'h3, RESP_SLVERR);
        ctl(32'h3737);
        rd(OFF_CTRL, 32'h3737, RESP_OKAY);
        wr(OFF_MASK, 32'h1, RESP_OKAY);
        msk = 2'h1;
        // Channel one disabled, then single shot on rising edges
        ctl(32'h0030);
        fire(2'h0, 1'b1, 2'h0);
        fire(2'h0, 1'b0, 2'h0);
        ctl(32'h0011);
        fire(2'h0, 1'b1, 2'h1);
        fire(2'h0, 1'b0, 2'h0);
        fire(2'h0, 1'b1, 2'h0);
        rd(OFF_STATE, 32'h14, RESP_OKAY);
        // Continuous on falling edges; last capture masked
        ctl(32'h0000);
        ctl(32'h0023);
        fire(2'h0, 1'b0, 2'h1);
        fire(2'h0, 1'b1, 2'h0);
        wr(OFF_MASK, 32'h0, RESP_OKAY);
        msk = 2'h0;
        fire(2'h0, 1'b0, 2'h1);
        wr(OFF_MASK, 32'h3, RESP_OKAY);
        msk = 2'h3;
        // Channel two on internal sources, both edges
        ctl(32'h3700);
        fire(2'h0, 1'b1, 2'h0);
        fire(2'h1, 1'b1, 2'h2);
        wr(OFF_ALTSEL, 32'h2, RESP_OKAY);
        fire(2'h1, 1'b0, 2'h0);
        fire(2'h2, 1'b1, 2'h2);
        // Both channels with their own settings
        ctl(32'h3713);
        fire(2'h0, 1'b0, 2'h0);
        fire(2'h0, 1'b1, 2'h1);
        fire(2'h2, 1'b0, 2'h2);
        ctl(32'h3313);
        fire(2'h0, 1'b0, 2'h2);
        fire(2'h0, 1'b1, 2'h3);
        give_verdict();
    end
endmodule
`default_nettype wire
